// File: hw/uft_baud.v
`timescale 1ns/1ps
module uft_baud (
  input  wire        clk_i,
  input  wire        arst_n_i,
  input  wire [15:0] div_i,
  input  wire        load_i,
  output reg         tick_o,
  output reg         baud_o
);
`include "uft_map.vh"
  reg  [15:0] cnt_reg;

  // A divisor of zero parks the generator rather than wrapping
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg <= `UFT_RST_DIV;
      tick_o  <= 1'b0;
      baud_o  <= 1'b0;
    end else if (div_i == 16'h0000) begin
      cnt_reg <= div_i;
      tick_o  <= 1'b0;
      baud_o  <= 1'b0;
    end else if (load_i) begin
      // A load opens a full period just as a tick does, minus the pulse
      cnt_reg <= div_i;
      tick_o  <= 1'b0;
      baud_o  <= 1'b1;
    end else if (cnt_reg <= 16'h0001) begin
      cnt_reg <= div_i;
      tick_o  <= 1'b1;
      baud_o  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg - 16'h0001;
      tick_o  <= 1'b0;
      baud_o  <= (cnt_reg - 16'h0001) > {1'b0, div_i[15:1]};
    end
  end
endmodule // uft_baud

// File: hw/uft_fifo.v
`timescale 1ns/1ps
module uft_fifo (
  input  wire       clk_i,
  input  wire       arst_n_i,
  input  wire       clr_i,
  input  wire       one_deep_i,
  input  wire       push_i,
  input  wire [7:0] din_i,
  input  wire       pop_i,
  output wire [7:0] dout_o,
  output wire [4:0] count_o,
  output wire       full_o,
  output wire       empty_o
);
`include "uft_map.vh"
  reg  [7:0] mem_reg [0:15];
  reg  [3:0] wr_reg;
  reg  [3:0] rd_reg;
  reg  [4:0] cnt_reg;
  wire       do_push;
  wire       do_pop;
  genvar     gi;

  // Disabled mode behaves as a single holding register
  assign full_o  = one_deep_i ? (cnt_reg != 5'h00) : (cnt_reg == `UFT_DEPTH);
  assign empty_o = (cnt_reg == 5'h00);
  assign do_push = push_i & ~full_o;
  assign do_pop  = pop_i & ~empty_o;
  assign dout_o  = mem_reg[rd_reg];
  assign count_o = cnt_reg;

  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_ent
      localparam [31:0] IDX = gi;
      always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          mem_reg[gi] <= 8'h00;
        end else if (do_push && wr_reg == IDX[3:0]) begin
          mem_reg[gi] <= din_i;
        end
      end
    end
  endgenerate

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_reg  <= 4'h0;
      rd_reg  <= 4'h0;
      cnt_reg <= 5'h00;
    end else if (clr_i) begin
      wr_reg  <= 4'h0;
      rd_reg  <= 4'h0;
      cnt_reg <= 5'h00;
    end else begin
      if (do_push) begin
        wr_reg <= wr_reg + 4'h1;
      end
      if (do_pop) begin
        rd_reg <= rd_reg + 4'h1;
      end
      if (do_push && !do_pop) begin
        cnt_reg <= cnt_reg + 5'h01;
      end else if (do_pop && !do_push) begin
        cnt_reg <= cnt_reg - 5'h01;
      end
    end
  end
endmodule // uft_fifo

// File: hw/uft_map.vh
`ifndef UFT_MAP_VH
`define UFT_MAP_VH
// ----------------------------------------------------------------------
// Register offsets (4-bit address)
// ----------------------------------------------------------------------
`define UFT_ADR_DATA      4'h0
`define UFT_ADR_IEN       4'h1
`define UFT_ADR_ISR_FCTL  4'h2
`define UFT_ADR_LCTL      4'h3
`define UFT_ADR_LSTAT     4'h5
`define UFT_ADR_EVT_STAT  4'h8
`define UFT_ADR_EVT_MASK  4'h9
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define UFT_FCTL_EN       0
`define UFT_FCTL_RXCLR    1
`define UFT_FCTL_TXCLR    2
`define UFT_FCTL_TRIG_LO  6
`define UFT_FCTL_TRIG_HI  7
`define UFT_IEN_RX        0
`define UFT_LCTL_WL_LO    0
`define UFT_LCTL_WL_HI    1
`define UFT_LCTL_DLAB     7
`define UFT_LSR_DR        0
`define UFT_LSR_OE        1
`define UFT_LSR_THRE      5
`define UFT_LSR_TEMT      6
`define UFT_EVT_RXLVL     0
`define UFT_EVT_RXTO      1
`define UFT_EVT_TXEMPTY   2
// ----------------------------------------------------------------------
// Reset values and interrupt identity codes
// ----------------------------------------------------------------------
`define UFT_RST_BYTE      8'h00
`define UFT_RST_DIV       16'h0001
`define UFT_RST_DIV_LO    8'h01
`define UFT_ISR_NONE      8'h01
`define UFT_ISR_RXLVL     8'h04
`define UFT_ISR_RXTO      8'h0c
`define UFT_ISR_FIFO_ON   8'hc0
// ----------------------------------------------------------------------
// Counts
// ----------------------------------------------------------------------
`define UFT_DEPTH         5'h10
`define UFT_TRIG0         5'h01
`define UFT_TRIG1         5'h04
`define UFT_TRIG2         5'h08
`define UFT_TRIG3         5'h0e
`define UFT_WL_BASE       6'h05
`define UFT_TO_MULT       2
`define UFT_TO_ADD        6'h0c
`define UFT_SIXTEENTHS    4'hf
`endif

// File: hw/uft_top.v
// How it works
// - Sixteen-byte send and receive queues, active only with FIFO enable bit 0.
// - Receive trigger level is programmable; transmit side has none.
// - Unread received bytes below trigger level raise a time-out interrupt.
// - Data-ready and time-out share one priority, enabled by enable bit 0.
// - Data interrupt rises when receive count reaches the trigger level.
// - No time-out interrupt while the receive queue is empty.
// - Time-out counter clears at each stop-bit center and each data read.
// - Time-out length in bit times is four times word length plus twelve.
// - Generator divides the input clock by any divisor 1 to 65535.
// - Baud clock output runs at sixteen times the bit rate; at divisor 1 it stays high.
// - Divisor lives in a high and a low byte register.
// - Divisor bytes are reachable only while line control bit 7 is set.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module uft_top (
  input  wire       clk_i,
  input  wire       arst_n_i,
  input  wire [3:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  input  wire       rx_valid_i,
  input  wire [7:0] rx_data_i,
  input  wire       rx_stop_center_i,
  output reg        tx_valid_o,
  output reg  [7:0] tx_data_o,
  input  wire       tx_take_i,
  output reg        sample_tick_o,
  output reg        baud_clock_out_o,
  output reg        irq_o
);
`include "uft_map.vh"
  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg  [7:0]  fifo_control_reg;
  reg  [7:0]  interrupt_enable_reg;
  reg  [7:0]  line_control_reg;
  reg  [7:0]  divisor_low_byte_reg;
  reg  [7:0]  divisor_high_byte_reg;
  reg  [2:0]  evt_stat_reg;
  reg  [2:0]  evt_mask_reg;
  reg         overrun_reg;
  reg         to_pend_reg;
  reg  [5:0]  to_cnt_reg;
  reg  [3:0]  sixteenth_reg;
  reg         tx_empty_d_reg;
  reg         fifo_on_d_reg;
  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  wire        dlab    = line_control_reg[`UFT_LCTL_DLAB];
  wire        fifo_on = fifo_control_reg[`UFT_FCTL_EN];
  wire        wr_data = wr_i && addr_i == `UFT_ADR_DATA && !dlab;
  wire        rd_data = rd_i && addr_i == `UFT_ADR_DATA && !dlab;
  wire        wr_dll  = wr_i && addr_i == `UFT_ADR_DATA && dlab;
  wire        wr_dlm  = wr_i && addr_i == `UFT_ADR_IEN && dlab;
  wire        wr_ien  = wr_i && addr_i == `UFT_ADR_IEN && !dlab;
  wire        wr_fctl = wr_i && addr_i == `UFT_ADR_ISR_FCTL;
  wire        rd_lsr  = rd_i && addr_i == `UFT_ADR_LSTAT;
  wire        wr_evt  = wr_i && addr_i == `UFT_ADR_EVT_STAT;
  // --------------------------------------------------------------------
  // Queues
  // --------------------------------------------------------------------
  wire [7:0]  rx_dout;
  wire [4:0]  rx_count;
  wire        rx_full;
  wire        rx_empty;
  wire [7:0]  tx_dout;
  wire        tx_full;
  wire        tx_empty;
  wire        fifo_flip = fifo_on != fifo_on_d_reg;
  wire        rx_clr = fifo_flip |
              (wr_fctl & wdata_i[`UFT_FCTL_RXCLR]);
  wire        tx_clr = fifo_flip |
              (wr_fctl & wdata_i[`UFT_FCTL_TXCLR]);
  wire        tx_load = !tx_empty && (!tx_valid_o || tx_take_i);

  // Disabled queues shrink to one byte each
  uft_fifo u_rx (
    .clk_i      (clk_i),
    .arst_n_i   (arst_n_i),
    .clr_i      (rx_clr),
    .one_deep_i (!fifo_on),
    .push_i     (rx_valid_i),
    .din_i      (rx_data_i),
    .pop_i      (rd_data),
    .dout_o     (rx_dout),
    .count_o    (rx_count),
    .full_o     (rx_full),
    .empty_o    (rx_empty)
  );

  uft_fifo u_tx (
    .clk_i      (clk_i),
    .arst_n_i   (arst_n_i),
    .clr_i      (tx_clr),
    .one_deep_i (!fifo_on),
    .push_i     (wr_data),
    .din_i      (wdata_i),
    .pop_i      (tx_load),
    .dout_o     (tx_dout),
    .count_o    (),
    .full_o     (tx_full),
    .empty_o    (tx_empty)
  );
  // --------------------------------------------------------------------
  // Baud generator
  // --------------------------------------------------------------------
  wire        tick;
  wire        baud;
  // The generator sees the byte being written, so a restart uses it
  wire [15:0] div_next = {wr_dlm ? wdata_i : divisor_high_byte_reg,
                          wr_dll ? wdata_i : divisor_low_byte_reg};
  uft_baud u_baud (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .div_i    (div_next),
    .load_i   (wr_dll | wr_dlm),
    .tick_o   (tick),
    .baud_o   (baud)
  );
  // --------------------------------------------------------------------
  // Trigger and time-out
  // --------------------------------------------------------------------
  reg  [4:0]  trig_level;
  always @* begin
    case (fifo_control_reg[`UFT_FCTL_TRIG_HI:`UFT_FCTL_TRIG_LO])
      2'b00:   trig_level = `UFT_TRIG0;
      2'b01:   trig_level = `UFT_TRIG1;
      2'b10:   trig_level = `UFT_TRIG2;
      default: trig_level = `UFT_TRIG3;
    endcase
    if (!fifo_on) begin
      trig_level = `UFT_TRIG0;
    end
  end

  wire        rx_lvl   = rx_count >= trig_level;
  wire [5:0]  word_len = `UFT_WL_BASE +
              {4'h0, line_control_reg[`UFT_LCTL_WL_HI:`UFT_LCTL_WL_LO]};
  // Start, parity and stop bits stay out of the limit
  wire [5:0]  to_limit = (word_len << `UFT_TO_MULT) + `UFT_TO_ADD;
  wire        bit_tick = tick && sixteenth_reg == `UFT_SIXTEENTHS;
  wire        to_hit   = bit_tick && to_cnt_reg + 6'h01 >= to_limit;
  wire        rx_ien   = interrupt_enable_reg[`UFT_IEN_RX];

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sixteenth_reg <= 4'h0;
      to_cnt_reg    <= 6'h00;
      to_pend_reg   <= 1'b0;
    end else begin
      if (tick) begin
        sixteenth_reg <= sixteenth_reg + 4'h1;
      end
      if (rx_stop_center_i || rd_data || rx_empty || !fifo_on) begin
        to_cnt_reg <= 6'h00;
      end else if (bit_tick && to_cnt_reg < to_limit) begin
        to_cnt_reg <= to_cnt_reg + 6'h01;
      end
      // A read empties the byte the time-out was about, so it wins
      if (rd_data || rx_empty || !fifo_on) begin
        to_pend_reg <= 1'b0;
      end else if (to_hit && !rx_lvl) begin
        to_pend_reg <= 1'b1;
      end
    end
  end
  // --------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fifo_control_reg      <= `UFT_RST_BYTE;
      interrupt_enable_reg  <= `UFT_RST_BYTE;
      line_control_reg      <= `UFT_RST_BYTE;
      divisor_low_byte_reg  <= `UFT_RST_DIV_LO;
      divisor_high_byte_reg <= `UFT_RST_BYTE;
      evt_mask_reg          <= 3'h0;
      fifo_on_d_reg         <= 1'b0;
    end else begin
      fifo_on_d_reg <= fifo_on;
      if (wr_fctl) begin
        // Clear bits act once and are not stored
        fifo_control_reg <= wdata_i & 8'hc1;
      end
      if (wr_ien) begin
        interrupt_enable_reg <= wdata_i & 8'h0f;
      end
      if (wr_i && addr_i == `UFT_ADR_LCTL) begin
        line_control_reg <= wdata_i;
      end
      if (wr_dll) begin
        divisor_low_byte_reg <= wdata_i;
      end
      if (wr_dlm) begin
        divisor_high_byte_reg <= wdata_i;
      end
      if (wr_i && addr_i == `UFT_ADR_EVT_MASK) begin
        evt_mask_reg <= wdata_i[2:0];
      end
    end
  end
  // --------------------------------------------------------------------
  // Events and interrupt
  // --------------------------------------------------------------------
  wire [2:0]  evt_set;
  assign evt_set[`UFT_EVT_RXLVL]   = rx_ien & rx_lvl & !rx_empty;
  assign evt_set[`UFT_EVT_RXTO]    = rx_ien & to_pend_reg;
  assign evt_set[`UFT_EVT_TXEMPTY] = tx_empty & !tx_empty_d_reg;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      evt_stat_reg   <= 3'h0;
      overrun_reg    <= 1'b0;
      tx_empty_d_reg <= 1'b1;
      irq_o          <= 1'b0;
    end else begin
      tx_empty_d_reg <= tx_empty;
      // A new event beats a write-one clear in the same cycle
      evt_stat_reg <= (evt_stat_reg & ~({3{wr_evt}} & wdata_i[2:0])) |
                      evt_set;
      if (rx_valid_i && rx_full && !rd_data) begin
        overrun_reg <= 1'b1;
      end else if (rd_lsr) begin
        overrun_reg <= 1'b0;
      end
      irq_o <= |(evt_stat_reg & evt_mask_reg);
    end
  end
  // --------------------------------------------------------------------
  // Read data and outputs
  // --------------------------------------------------------------------
  reg  [7:0]  isr_val;
  reg  [7:0]  lsr_val;
  reg  [7:0]  rd_next;
  always @* begin
    isr_val = fifo_on ? `UFT_ISR_FIFO_ON : 8'h00;
    // Both receive causes sit on one level; time-out code shown first
    if (rx_ien && to_pend_reg) begin
      isr_val = isr_val | `UFT_ISR_RXTO;
    end else if (rx_ien && rx_lvl && !rx_empty) begin
      isr_val = isr_val | `UFT_ISR_RXLVL;
    end else begin
      isr_val = isr_val | `UFT_ISR_NONE;
    end
    lsr_val = 8'h00;
    lsr_val[`UFT_LSR_DR]   = !rx_empty;
    lsr_val[`UFT_LSR_OE]   = overrun_reg;
    lsr_val[`UFT_LSR_THRE] = tx_empty;
    lsr_val[`UFT_LSR_TEMT] = tx_empty & !tx_valid_o;
    case (addr_i)
      `UFT_ADR_DATA:
        rd_next = dlab ? divisor_low_byte_reg : rx_dout;
      `UFT_ADR_IEN:
        rd_next = dlab ? divisor_high_byte_reg : interrupt_enable_reg;
      `UFT_ADR_ISR_FCTL: rd_next = isr_val;
      `UFT_ADR_LCTL:     rd_next = line_control_reg;
      `UFT_ADR_LSTAT:    rd_next = lsr_val;
      `UFT_ADR_EVT_STAT: rd_next = {5'h00, evt_stat_reg};
      `UFT_ADR_EVT_MASK: rd_next = {5'h00, evt_mask_reg};
      default:           rd_next = 8'h00;
    endcase
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o          <= 8'h00;
      tx_valid_o       <= 1'b0;
      tx_data_o        <= 8'h00;
      sample_tick_o    <= 1'b0;
      baud_clock_out_o <= 1'b0;
    end else begin
      if (rd_i) begin
        rdata_o <= rd_next;
      end
      if (tx_clr) begin
        tx_valid_o <= 1'b0;
      end else if (tx_load) begin
        tx_valid_o <= 1'b1;
        tx_data_o  <= tx_dout;
      end else if (tx_take_i) begin
        tx_valid_o <= 1'b0;
      end
      sample_tick_o    <= tick;
      baud_clock_out_o <= baud;
    end
  end
endmodule // uft_top

// File: verification/uft_monitor.sv
`timescale 1ns/1ps
module uft_monitor (
  input logic       clk_i,
  input logic       arst_n_i,
  input logic [3:0] addr_i,
  input logic [7:0] wdata_i,
  input logic       wr_i,
  input logic       rd_i,
  input logic [7:0] rdata_o,
  input logic       rx_valid_i,
  input logic [7:0] rx_data_i,
  input logic       rx_stop_center_i,
  input logic       tx_valid_o,
  input logic [7:0] tx_data_o,
  input logic       tx_take_i,
  input logic       sample_tick_o,
  input logic       baud_clock_out_o,
  input logic       irq_o
);
  // ----------------------------------------------------------------
  // Shadow of the divisor, access bit and mask, seen from the bus
  // ----------------------------------------------------------------
  logic        dlab;
  logic [15:0] dv;
  logic [7:0]  msk;
  logic [15:0] gap;
  logic [15:0] bgap;
  logic        rst_t;
  logic        rst_b;
  logic        bprev;
  logic        dwr_d;
  wire         dwr  = wr_i && dlab && (addr_i < 4'h2);
  wire         brise = baud_clock_out_o && !bprev;

  // Restart flags skip the first period after a divisor write or reset;
  // a stale pulse may still leave the output stage one cycle later
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dlab  <= 1'b0;
      dv    <= 16'h0001;
      msk   <= 8'h00;
      gap   <= 16'h0000;
      bgap  <= 16'h0000;
      rst_t <= 1'b1;
      rst_b <= 1'b1;
      bprev <= 1'b0;
      dwr_d <= 1'b1;
    end else begin
      dwr_d <= dwr;
      if (wr_i && addr_i == 4'h3) dlab <= wdata_i[7];
      if (dwr && addr_i == 4'h0) dv[7:0] <= wdata_i;
      if (dwr && addr_i == 4'h1) dv[15:8] <= wdata_i;
      if (wr_i && addr_i == 4'h9) msk <= wdata_i;
      gap   <= (sample_tick_o || dwr || dwr_d) ? 16'h0000 : gap + 16'h0001;
      bgap  <= (brise || dwr || dwr_d) ? 16'h0000 : bgap + 16'h0001;
      rst_t <= (dwr || dwr_d) ? 1'b1 : (sample_tick_o ? 1'b0 : rst_t);
      rst_b <= (dwr || dwr_d) ? 1'b1 : (brise ? 1'b0 : rst_b);
      bprev <= baud_clock_out_o;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_data_rd;
    rd_i && addr_i == 4'h0 && !dlab;
  endsequence
  sequence s_id_rd;
    rd_i && addr_i == 4'h2;
  endsequence

  property p_tick_gap;
    sample_tick_o && !rst_t |-> gap == dv - 16'h0001;
  endproperty
  property p_tick_bound;
    dv != 16'h0000 |-> gap <= dv;
  endproperty
  property p_baud_gap;
    brise && !rst_b |-> bgap == dv - 16'h0001;
  endproperty
  property p_baud_div1;
    (dv == 16'h0001)[*4] |-> baud_clock_out_o;
  endproperty
  property p_tx_load;
    wr_i && addr_i == 4'h0 && !dlab |-> ##2 tx_valid_o;
  endproperty
  property p_div_no_tx;
    wr_i && addr_i == 4'h0 && dlab && !tx_valid_o && !$past(wr_i)
      |=> !tx_valid_o ##1 !tx_valid_o;
  endproperty
  property p_mask_quiet;
    (msk == 8'h00)[*2] |=> !irq_o;
  endproperty
  property p_div_read;
    rd_i && addr_i == 4'h1 && dlab |=> rdata_o == dv[15:8];
  endproperty
  property p_to_clear;
    s_data_rd ##2 s_id_rd |=> rdata_o[3:0] != 4'hc;
  endproperty

  a_tick_gap: assert property (p_tick_gap)
    else $error("sample tick spacing differs from divisor");
  a_tick_bound: assert property (p_tick_bound)
    else $error("sample tick late after divisor change");
  a_baud_gap: assert property (p_baud_gap)
    else $error("baud clock period differs from divisor");
  a_baud_div1: assert property (p_baud_div1)
    else $error("baud clock not high with divisor one");
  a_tx_load: assert property (p_tx_load)
    else $error("data write did not reach transmit output");
  a_div_no_tx: assert property (p_div_no_tx)
    else $error("divisor write leaked into transmit queue");
  a_mask_quiet: assert property (p_mask_quiet)
    else $error("interrupt high with mask clear");
  a_div_read: assert property (p_div_read)
    else $error("divisor high byte read back wrong");
  a_to_clear: assert property (p_to_clear)
    else $error("time-out id still shown after data read");
endmodule // uft_monitor

bind uft_top uft_monitor uft_monitor_i (.*);

// File: verification/uft_ser_model.sv
`timescale 1ns/1ps
module uft_ser_model (
  input  logic       clk_i,
  input  logic       arst_n_i,
  input  logic       send_i,
  input  logic [7:0] byte_i,
  input  logic       stall_i,
  input  logic       tx_valid_i,
  input  logic [7:0] tx_data_i,
  output logic       rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic       rx_stop_center_o,
  output logic       tx_take_o,
  output logic [7:0] taken_o,
  output logic [7:0] last_o
);
  // Idle data lines flip every cycle so a stale byte is never mistaken
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_valid_o       <= 1'b0;
      rx_data_o        <= 8'h00;
      rx_stop_center_o <= 1'b0;
      tx_take_o        <= 1'b0;
      taken_o          <= 8'h00;
      last_o           <= 8'h00;
    end else begin
      rx_valid_o       <= send_i;
      rx_stop_center_o <= send_i;
      rx_data_o        <= send_i ? byte_i : ~rx_data_o;
      tx_take_o        <= tx_valid_i && !stall_i && !tx_take_o;
      if (tx_take_o && tx_valid_i) begin
        taken_o <= taken_o + 8'h01;
        last_o  <= tx_data_i;
      end
    end
  end
endmodule // uft_ser_model

// File: verification/uft_top_tb.sv
`timescale 1ns/1ps
module uft_top_tb;
  logic       clk_i = 1'b0;
  logic       arst_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic       send = 1'b0;
  logic [7:0] sbyte = 8'h00;
  logic       stall = 1'b0;
  wire  [7:0] rdata_o, rx_data_i, tx_data_o, taken, last;
  wire        rx_valid_i, rx_stop_center_i, tx_valid_o, tx_take_i;
  wire        sample_tick_o, baud_clock_out_o, irq_o;
  int         err_count = 0;
  int         n_compared = 0;
  int         t, i, k, lim, nt, nb;
  logic [7:0] d;
  logic       bp;
  int         lvl [4] = '{1, 4, 8, 14};

  uft_top uft_top_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
    .rx_stop_center_i(rx_stop_center_i), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_take_i(tx_take_i),
    .sample_tick_o(sample_tick_o), .baud_clock_out_o(baud_clock_out_o),
    .irq_o(irq_o));
  uft_ser_model uft_ser_model_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .send_i(send), .byte_i(sbyte), .stall_i(stall), .tx_valid_i(tx_valid_o),
    .tx_data_i(tx_data_o), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
    .rx_stop_center_o(rx_stop_center_i), .tx_take_o(tx_take_i),
    .taken_o(taken), .last_o(last));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Bus, serial, timing and check tasks
  // ----------------------------------------------------------------
  task print_verdict;
    $display("compared=%0d mismatches=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    addr_i <= a; wdata_i <= v; wr_i <= 1'b1;
    @(posedge clk_i); wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task rd(input logic [3:0] a);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_i); rd_i <= 1'b0;
    #1 d = rdata_o;
    @(posedge clk_i);
  endtask
  task rchk(input logic [3:0] a, input logic [7:0] exp);
    rd(a);
    chk(d, exp);
  endtask
  task rx_send(input logic [7:0] b);
    send <= 1'b1; sbyte <= b;
    @(posedge clk_i); send <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task count_ticks(input int n);
    nt = 0; nb = 0; #1 bp = baud_clock_out_o;
    repeat (n) begin
      @(posedge clk_i); #1;
      if (sample_tick_o === 1'b1) nt++;
      if (baud_clock_out_o === 1'b1 && bp === 1'b0) nb++;
      bp = baud_clock_out_o;
    end
    @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    idle(12); arst_n_i <= 1'b1; @(posedge clk_i);
    rchk(4'h1, 8'h00); rchk(4'h2, 8'h01); rchk(4'h3, 8'h00);
    rchk(4'h5, 8'h60); rchk(4'h9, 8'h00); rchk(4'h4, 8'h00);
    // Divisor 3 then 1; 1 keeps the time-out waits short
    wr(4'h3, 8'h80); wr(4'h0, 8'h03); wr(4'h1, 8'h00);
    rchk(4'h0, 8'h03); rchk(4'h1, 8'h00);
    idle(8); count_ticks(30);
    chk(nt[7:0], 8'h0a); chk(nb[7:0], 8'h0a);
    wr(4'h0, 8'h01); idle(4); count_ticks(16);
    chk(nt[7:0], 8'h10);
    wr(4'h3, 8'h03); wr(4'h1, 8'h01);
    // Queues off: one deep, second byte overruns
    rx_send(8'h11); rx_send(8'h22);
    rchk(4'h5, 8'h63); rchk(4'h2, 8'h04); rchk(4'h0, 8'h11);
    rchk(4'h5, 8'h60);
    // Stalled far side: one byte staged plus sixteen queued, next dropped
    wr(4'h2, 8'h07); stall <= 1'b1;
    for (i = 0; i < 16; i++) wr(4'h0, 8'h40 + i[7:0]);
    wr(4'h0, 8'hee); wr(4'h0, 8'hdd); rchk(4'h5, 8'h00); stall <= 1'b0;
    k = 0;
    while (k < 200 && taken !== 8'h11) begin k++; idle(1); end
    idle(10); chk(taken, 8'h11); chk(last, 8'hee);
    rchk(4'h8, 8'h05); wr(4'h8, 8'h05); rchk(4'h8, 8'h00);
    rchk(4'h2, 8'hc1); rchk(4'h5, 8'h60);
    // Every trigger code, level reached exactly at its count
    for (t = 0; t < 4; t++) begin
      wr(4'h2, {t[1:0], 6'h07});
      for (i = 0; i < lvl[t] - 1; i++) rx_send(i[7:0]);
      rchk(4'h2, 8'hc1); rx_send(8'haa);
      rchk(4'h2, 8'hc4); chk({7'h00, irq_o}, 8'h00);
    end
    wr(4'h9, 8'h03); idle(2); chk({7'h00, irq_o}, 8'h01);
    for (i = 0; i < 14; i++) begin
      rchk(4'h5, 8'h61);
      rchk(4'h0, (i == 13) ? 8'haa : i[7:0]);
    end
    rchk(4'h5, 8'h60); wr(4'h8, 8'hff); rchk(4'h8, 8'h00);
    idle(2); chk({7'h00, irq_o}, 8'h00);
    // Time-out for word lengths 5 and 8
    for (t = 0; t < 4; t += 3) begin
      lim = (4 * (5 + t) + 12) * 16;
      wr(4'h3, t[7:0]); wr(4'h2, 8'hc7); rx_send(8'h55);
      idle(lim - 24); rchk(4'h2, 8'hc1);
      k = 0; d = 8'h00;
      while (k < 60 && d !== 8'hcc) begin k++; rd(4'h2); end
      chk(d, 8'hcc);
      idle(2); chk({7'h00, irq_o}, 8'h01);
      rchk(4'h0, 8'h55); rchk(4'h2, 8'hc1);
      wr(4'h8, 8'h02); idle(lim + 40); rchk(4'h2, 8'hc1);
      chk({7'h00, irq_o}, 8'h00);
    end
    // A new stop bit restarts the count
    rx_send(8'h31); idle(lim / 2); rx_send(8'h32);
    idle(lim / 2 + 30); rchk(4'h2, 8'hc1);
    rchk(4'h0, 8'h31); rchk(4'h0, 8'h32);
    print_verdict;
  end

  initial begin
    #2ms;
    err_count++;
    print_verdict;
  end
endmodule // uft_top_tb
